// ### tcwu_defines.svh
/*
 Constants for the 8-bit timer compare and waveform unit: register offsets,
 field positions, mode codes, counter limits and response codes.
 Assumes inclusion by bare name from every design file that needs them.
*/
`ifndef TCWU_DEFINES_SVH
`define TCWU_DEFINES_SVH

`define TCWU_ADDR_W        6
`define TCWU_OFF_CTRL      6'h00
`define TCWU_OFF_COUNT     6'h04
`define TCWU_OFF_CMPA      6'h08
`define TCWU_OFF_CMPB      6'h0c
`define TCWU_OFF_FLAGS     6'h10
`define TCWU_OFF_STROBE    6'h14
`define TCWU_OFF_PORT      6'h18
`define TCWU_OFF_STATUS    6'h1c

// Control word fields
`define TCWU_CTRL_WGM_LSB  0
`define TCWU_CTRL_ACTA_LSB 4
`define TCWU_CTRL_ACTB_LSB 6
`define TCWU_CTRL_EN_BIT   8

// Flag word fields, write one to clear
`define TCWU_FLAG_OVF_BIT  0
`define TCWU_FLAG_CMA_BIT  1
`define TCWU_FLAG_CMB_BIT  2

// Strobe word fields
`define TCWU_STB_FOCA_BIT  0
`define TCWU_STB_FOCB_BIT  1
`define TCWU_STB_OVA_BIT   2
`define TCWU_STB_OVB_BIT   3

// Port word fields
`define TCWU_PORT_DIRA_BIT 0
`define TCWU_PORT_DIRB_BIT 1
`define TCWU_PORT_OUTA_BIT 2
`define TCWU_PORT_OUTB_BIT 3

`define TCWU_WGM_NORMAL    3'h0
`define TCWU_WGM_CTC       3'h2
`define TCWU_WGM_FAST_MAX  3'h3
`define TCWU_WGM_FAST_CMP  3'h7
`define TCWU_MAX           8'hff
`define TCWU_BOTTOM        8'h00
`define TCWU_RESP_OKAY     2'h0
`define TCWU_RESP_SLVERR   2'h2

`endif

// ### tcwu_pkg.sv
/*
 Types shared by the timer compare and waveform unit.
 Assumes tcwu_defines.svh for numeric constants.
*/
package tcwu_pkg;

  typedef enum logic [1:0] {
    TCWU_ACT_NONE,
    TCWU_ACT_TOGGLE,
    TCWU_ACT_CLEAR,
    TCWU_ACT_SET
  } tcwu_action_t;

  typedef enum logic [1:0] {
    TCWU_WR_IDLE,
    TCWU_WR_RESP
  } tcwu_wr_state_t;

endpackage : tcwu_pkg

// ### tcwu_sync.sv
/*
 Three-stage synchroniser for the external timer clock enable.
 Assumes a level input from another domain; output changes once stages two
 and three agree.
*/
module tcwu_sync (
  input  wire logic aclk,
  input  wire logic aresetn,
  input  wire logic din,
  output logic      dout
);

  typedef struct packed {
    logic [2:0] stage;
    logic       out;
  } tcwu_sync_state_t;

  tcwu_sync_state_t state_reg;
  tcwu_sync_state_t state_next;

  always_comb begin
    state_next       = state_reg;
    state_next.stage = {state_reg.stage[1:0], din};
    if (state_reg.stage[1] == state_reg.stage[2]) begin
      state_next.out = state_reg.stage[2];
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      state_reg <= '0;
    end else begin
      state_reg <= state_next;
    end
  end

  assign dout = state_reg.out;

endmodule : tcwu_sync

// ### tcwu_channel.sv
/*
 One compare channel: active compare value with PWM buffer, match flag and
 output state. Assumes tick is the timer clock enable on aclk.
*/
`include "tcwu_defines.svh"

module tcwu_channel (
  input  wire logic       aclk,
  input  wire logic       aresetn,
  input  wire logic       tick,
  input  wire logic       pwm_mode,
  input  wire logic       fast_mode,
  input  wire logic [7:0] count,
  input  wire logic       at_top,
  input  wire logic       block_match,
  input  wire logic [1:0] action,
  input  wire logic       cmp_wr,
  input  wire logic [7:0] cmp_wdata,
  input  wire logic       force_stb,
  input  wire logic       flag_clr,
  input  wire logic       state_wr,
  input  wire logic       state_wdata,
  output logic [7:0]      cmp_active,
  output logic [7:0]      cmp_buffer,
  output logic            match_flag,
  output logic            out_state
);

  typedef struct packed {
    logic [7:0] active;
    logic [7:0] buffer;
    logic       flag;
    logic       oc;
    logic       hit;
  } tcwu_chan_state_t;

  tcwu_chan_state_t s_reg;
  tcwu_chan_state_t s_next;
  logic             match;
  logic             apply;
  tcwu_pkg::tcwu_action_t act;

  assign act   = tcwu_pkg::tcwu_action_t'(action);
  assign match = (count == s_reg.active) && !block_match;
  assign apply = (tick && match) || (force_stb && !pwm_mode);

  always_comb begin
    s_next     = s_reg;
    s_next.hit = 1'b0;
    if (cmp_wr) begin
      s_next.buffer = cmp_wdata;
      if (!pwm_mode) begin
        s_next.active = cmp_wdata;
      end
    end
    if (tick) begin
      s_next.hit = match;
      if (pwm_mode && at_top) begin
        s_next.active = cmp_wr ? cmp_wdata : s_reg.buffer;
      end
    end
    // Match flag set one clock after a matching tick, only if tick is also high on that next clock; set beats clear
    if (flag_clr) begin
      s_next.flag = 1'b0;
    end
    if (tick && s_reg.hit) begin
      s_next.flag = 1'b1;
    end
    // Action read live, so a new value acts at the next match
    if (apply) begin
      unique case (act)
        tcwu_pkg::TCWU_ACT_NONE:   s_next.oc = s_reg.oc;
        tcwu_pkg::TCWU_ACT_TOGGLE: s_next.oc = !s_reg.oc;
        tcwu_pkg::TCWU_ACT_CLEAR:  s_next.oc = 1'b0;
        tcwu_pkg::TCWU_ACT_SET:    s_next.oc = 1'b1;
      endcase
    end
    // Preset after the action, so a forced no-action cannot undo it
    if (state_wr) begin
      s_next.oc = state_wdata;
    end
    // Fast PWM bottom action; match at top wins so output stays constant
    if (tick && fast_mode && at_top && !(match && count == s_reg.active)) begin
      if (act == tcwu_pkg::TCWU_ACT_CLEAR) begin
        s_next.oc = 1'b1;
      end else if (act == tcwu_pkg::TCWU_ACT_SET) begin
        s_next.oc = 1'b0;
      end
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_reg <= '0;
    end else begin
      s_reg <= s_next;
    end
  end

  assign cmp_active = s_reg.active;
  assign cmp_buffer = s_reg.buffer;
  assign match_flag = s_reg.flag;
  assign out_state  = s_reg.oc;

endmodule : tcwu_channel

// ### tcwu_timer.sv
/*
 8-bit timer counter with two compare channels, waveform modes normal,
 clear-on-match and fast PWM, port override and AXI4-Lite register access.
 Assumes timer_tick_in is the timer clock enable from an outside prescaler or
 oscillator and is synchronised here; pins are resolved outside.
*/
`include "tcwu_defines.svh"

module tcwu_timer (
  input  wire logic                     aclk,
  input  wire logic                     aresetn,
  input  wire logic                     timer_tick_in,
  input  wire logic                     ovf_service_ack,
  input  wire logic                     cma_service_ack,
  input  wire logic                     cmb_service_ack,
  input  wire logic [`TCWU_ADDR_W-1:0]  s_axi_awaddr,
  input  wire logic                     s_axi_awvalid,
  output logic                          s_axi_awready,
  input  wire logic [31:0]              s_axi_wdata,
  input  wire logic [3:0]               s_axi_wstrb,
  input  wire logic                     s_axi_wvalid,
  output logic                          s_axi_wready,
  output logic [1:0]                    s_axi_bresp,
  output logic                          s_axi_bvalid,
  input  wire logic                     s_axi_bready,
  input  wire logic [`TCWU_ADDR_W-1:0]  s_axi_araddr,
  input  wire logic                     s_axi_arvalid,
  output logic                          s_axi_arready,
  output logic [31:0]                   s_axi_rdata,
  output logic [1:0]                    s_axi_rresp,
  output logic                          s_axi_rvalid,
  input  wire logic                     s_axi_rready,
  output logic                          pin_a_out,
  output logic                          pin_a_oe,
  output logic                          pin_b_out,
  output logic                          pin_b_oe,
  output logic                          overflow_flag,
  output logic                          compare_match_flag_a,
  output logic                          compare_match_flag_b
);

  ////////////////////////////////////////////////////////////////////////////

  typedef struct packed {
    logic                    aw_hold;
    logic [`TCWU_ADDR_W-1:0] aw_addr;
    logic                    w_hold;
    logic [31:0]             w_data;
    logic [3:0]              w_strb;
    tcwu_pkg::tcwu_wr_state_t wr_st;
    logic [1:0]              bresp;
    logic                    rvalid;
    logic [31:0]             rdata;
    logic [1:0]              rresp;
    logic                    awrdy;
    logic                    wrdy;
    logic                    ardy;
    logic [2:0]              waveform_mode_select;
    logic [1:0]              compare_output_action_a;
    logic [1:0]              compare_output_action_b;
    logic                    clk_enable;
    logic [7:0]              counter_value;
    logic                    count_written;
    logic                    ovf;
    logic [1:0]              pin_direction_bit;
    logic [1:0]              port_out;
    logic                    pa_out;
    logic                    pa_oe;
    logic                    pb_out;
    logic                    pb_oe;
  } tcwu_top_state_t;

  tcwu_top_state_t r_reg;
  tcwu_top_state_t r_next;

  logic        tick_sync;
  logic        tick;
  logic        pwm_mode;
  logic        fast_mode;
  logic [7:0]  top_value;
  logic        at_top;
  logic        wr_go;
  logic [7:0]  wbyte;
  logic        wr_ctrl;
  logic        wr_count;
  logic        wr_cmpa;
  logic        wr_cmpb;
  logic        wr_flags;
  logic        wr_strobe;
  logic        wr_port;
  logic [7:0]  cmpa_active;
  logic [7:0]  cmpa_buffer;
  logic [7:0]  cmpb_active;
  logic [7:0]  cmpb_buffer;
  logic        flag_a;
  logic        flag_b;
  logic        state_a;
  logic        state_b;

  ////////////////////////////////////////////////////////////////////////////

  tcwu_sync u_tick_sync (
    .aclk    (aclk),
    .aresetn (aresetn),
    .din     (timer_tick_in),
    .dout    (tick_sync)
  );

  // Enable bit models the clock select; off freezes the counter
  assign tick      = tick_sync && r_reg.clk_enable;
  assign fast_mode = (r_reg.waveform_mode_select == `TCWU_WGM_FAST_MAX) ||
                     (r_reg.waveform_mode_select == `TCWU_WGM_FAST_CMP);
  assign pwm_mode  = fast_mode;
  assign top_value = (r_reg.waveform_mode_select == `TCWU_WGM_FAST_MAX) ? `TCWU_MAX :
                     cmpa_active;
  assign at_top    = fast_mode ? (r_reg.counter_value == top_value) :
                     (r_reg.counter_value == `TCWU_MAX);

  ////////////////////////////////////////////////////////////////////////////
  // AXI write decode

  assign wr_go     = r_reg.aw_hold && r_reg.w_hold && (r_reg.wr_st == tcwu_pkg::TCWU_WR_IDLE);
  assign wbyte     = r_reg.w_strb[0] ? r_reg.w_data[7:0] : 8'h00;
  assign wr_ctrl   = wr_go && (r_reg.aw_addr == `TCWU_OFF_CTRL)   && r_reg.w_strb[0];
  assign wr_count  = wr_go && (r_reg.aw_addr == `TCWU_OFF_COUNT)  && r_reg.w_strb[0];
  assign wr_cmpa   = wr_go && (r_reg.aw_addr == `TCWU_OFF_CMPA)   && r_reg.w_strb[0];
  assign wr_cmpb   = wr_go && (r_reg.aw_addr == `TCWU_OFF_CMPB)   && r_reg.w_strb[0];
  assign wr_flags  = wr_go && (r_reg.aw_addr == `TCWU_OFF_FLAGS)  && r_reg.w_strb[0];
  assign wr_strobe = wr_go && (r_reg.aw_addr == `TCWU_OFF_STROBE) && r_reg.w_strb[0];
  assign wr_port   = wr_go && (r_reg.aw_addr == `TCWU_OFF_PORT)   && r_reg.w_strb[0];

  ////////////////////////////////////////////////////////////////////////////

  tcwu_channel u_chan_a (
    .aclk        (aclk),
    .aresetn     (aresetn),
    .tick        (tick),
    .pwm_mode    (pwm_mode),
    .fast_mode   (fast_mode),
    .count       (r_reg.counter_value),
    .at_top      (at_top && fast_mode),
    .block_match (r_reg.count_written),
    .action      (r_reg.compare_output_action_a),
    .cmp_wr      (wr_cmpa),
    .cmp_wdata   (wbyte),
    .force_stb   (wr_strobe && wbyte[`TCWU_STB_FOCA_BIT]),
    .flag_clr    ((wr_flags && wbyte[`TCWU_FLAG_CMA_BIT]) || cma_service_ack),
    .state_wr    (wr_strobe && wbyte[`TCWU_STB_FOCA_BIT] && r_reg.compare_output_action_a == 2'h0),
    .state_wdata (wbyte[`TCWU_STB_OVA_BIT]),
    .cmp_active  (cmpa_active),
    .cmp_buffer  (cmpa_buffer),
    .match_flag  (flag_a),
    .out_state   (state_a)
  );

  tcwu_channel u_chan_b (
    .aclk        (aclk),
    .aresetn     (aresetn),
    .tick        (tick),
    .pwm_mode    (pwm_mode),
    .fast_mode   (fast_mode),
    .count       (r_reg.counter_value),
    .at_top      (at_top && fast_mode),
    .block_match (r_reg.count_written),
    .action      (r_reg.compare_output_action_b),
    .cmp_wr      (wr_cmpb),
    .cmp_wdata   (wbyte),
    .force_stb   (wr_strobe && wbyte[`TCWU_STB_FOCB_BIT]),
    .flag_clr    ((wr_flags && wbyte[`TCWU_FLAG_CMB_BIT]) || cmb_service_ack),
    .state_wr    (wr_strobe && wbyte[`TCWU_STB_FOCB_BIT] && r_reg.compare_output_action_b == 2'h0),
    .state_wdata (wbyte[`TCWU_STB_OVB_BIT]),
    .cmp_active  (cmpb_active),
    .cmp_buffer  (cmpb_buffer),
    .match_flag  (flag_b),
    .out_state   (state_b)
  );

  ////////////////////////////////////////////////////////////////////////////

  always_comb begin
    r_next = r_reg;

    // Write address and data taken independently, one write in flight
    if (s_axi_awvalid && r_reg.awrdy) begin
      r_next.aw_hold = 1'b1;
      r_next.aw_addr = s_axi_awaddr;
    end
    if (s_axi_wvalid && r_reg.wrdy) begin
      r_next.w_hold = 1'b1;
      r_next.w_data = s_axi_wdata;
      r_next.w_strb = s_axi_wstrb;
    end
    unique case (r_reg.wr_st)
      tcwu_pkg::TCWU_WR_IDLE: begin
        if (wr_go) begin
          r_next.wr_st = tcwu_pkg::TCWU_WR_RESP;
          r_next.bresp = (r_reg.aw_addr[1:0] != 2'h0 || r_reg.aw_addr > `TCWU_OFF_STATUS) ?
                         `TCWU_RESP_SLVERR : `TCWU_RESP_OKAY;
        end
      end
      tcwu_pkg::TCWU_WR_RESP: begin
        if (s_axi_bready) begin
          r_next.wr_st   = tcwu_pkg::TCWU_WR_IDLE;
          r_next.aw_hold = 1'b0;
          r_next.w_hold  = 1'b0;
        end
      end
      default: r_next.wr_st = tcwu_pkg::TCWU_WR_IDLE;
    endcase

    // Read path
    if (r_reg.rvalid && s_axi_rready) begin
      r_next.rvalid = 1'b0;
    end
    if (s_axi_arvalid && r_reg.ardy) begin
      r_next.rvalid = 1'b1;
      r_next.rresp  = `TCWU_RESP_OKAY;
      r_next.rdata  = 32'h0000_0000;
      unique case (s_axi_araddr)
        `TCWU_OFF_CTRL:   r_next.rdata[8:0] = {r_reg.clk_enable, r_reg.compare_output_action_b,
                                               r_reg.compare_output_action_a, 1'b0,
                                               r_reg.waveform_mode_select};
        `TCWU_OFF_COUNT:  r_next.rdata[7:0] = r_reg.counter_value;
        `TCWU_OFF_CMPA:   r_next.rdata[7:0] = pwm_mode ? cmpa_buffer : cmpa_active;
        `TCWU_OFF_CMPB:   r_next.rdata[7:0] = pwm_mode ? cmpb_buffer : cmpb_active;
        `TCWU_OFF_FLAGS:  r_next.rdata[2:0] = {flag_b, flag_a, r_reg.ovf};
        `TCWU_OFF_STROBE: r_next.rdata[3:0] = {state_b, state_a, 2'h0};
        `TCWU_OFF_PORT:   r_next.rdata[3:0] = {r_reg.port_out, r_reg.pin_direction_bit};
        `TCWU_OFF_STATUS: r_next.rdata[7:0] = tick ? cmpa_active : 8'h00;
        default:          r_next.rresp      = `TCWU_RESP_SLVERR;
      endcase
    end

    // Control writes: action field never touches the counting logic
    if (wr_ctrl) begin
      r_next.waveform_mode_select    = wbyte[`TCWU_CTRL_WGM_LSB +: 3];
      r_next.compare_output_action_a = wbyte[`TCWU_CTRL_ACTA_LSB +: 2];
      r_next.compare_output_action_b = wbyte[`TCWU_CTRL_ACTB_LSB +: 2];
      r_next.clk_enable              = r_reg.w_strb[1] && r_reg.w_data[`TCWU_CTRL_EN_BIT];
    end
    if (wr_port) begin
      r_next.pin_direction_bit = wbyte[`TCWU_PORT_DIRB_BIT:`TCWU_PORT_DIRA_BIT];
      r_next.port_out          = wbyte[`TCWU_PORT_OUTB_BIT:`TCWU_PORT_OUTA_BIT];
    end

    // Counter; a software write wins and blocks the next tick's match
    if (tick) begin
      r_next.count_written = 1'b0;
      unique case (r_reg.waveform_mode_select)
        `TCWU_WGM_CTC: begin
          r_next.counter_value = (r_reg.counter_value == cmpa_active) ?
                                 `TCWU_BOTTOM : r_reg.counter_value + 8'h01;
        end
        `TCWU_WGM_FAST_MAX, `TCWU_WGM_FAST_CMP: begin
          r_next.counter_value = at_top ? `TCWU_BOTTOM : r_reg.counter_value + 8'h01;
        end
        default: begin
          r_next.counter_value = r_reg.counter_value + 8'h01;
        end
      endcase
    end
    if (wr_count) begin
      r_next.counter_value = wbyte;
      r_next.count_written = 1'b1;
    end

    // Overflow flag; set wins over clear
    if ((wr_flags && wbyte[`TCWU_FLAG_OVF_BIT]) || ovf_service_ack) begin
      r_next.ovf = 1'b0;
    end
    if (tick && at_top) begin
      r_next.ovf = 1'b1;
    end

    // Pin override chosen by action alone; direction still from port
    r_next.pa_oe  = r_reg.pin_direction_bit[0];
    r_next.pb_oe  = r_reg.pin_direction_bit[1];
    r_next.pa_out = r_reg.pin_direction_bit[0] &&
                    ((r_reg.compare_output_action_a != 2'h0) ? state_a : r_reg.port_out[0]);
    r_next.pb_out = r_reg.pin_direction_bit[1] &&
                    ((r_reg.compare_output_action_b != 2'h0) ? state_b : r_reg.port_out[1]);

    // Readies registered; low for one cycle after reset
    r_next.awrdy = !r_next.aw_hold;
    r_next.wrdy  = !r_next.w_hold;
    r_next.ardy  = !r_next.rvalid;
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      r_reg <= '0;
    end else begin
      r_reg <= r_next;
    end
  end

  ////////////////////////////////////////////////////////////////////////////

  assign s_axi_awready        = r_reg.awrdy;
  assign s_axi_wready         = r_reg.wrdy;
  assign s_axi_bvalid         = r_reg.wr_st == tcwu_pkg::TCWU_WR_RESP;
  assign s_axi_bresp          = r_reg.bresp;
  assign s_axi_arready        = r_reg.ardy;
  assign s_axi_rvalid         = r_reg.rvalid;
  assign s_axi_rdata          = r_reg.rdata;
  assign s_axi_rresp          = r_reg.rresp;
  assign pin_a_out            = r_reg.pa_out;
  assign pin_a_oe             = r_reg.pa_oe;
  assign pin_b_out            = r_reg.pb_out;
  assign pin_b_oe             = r_reg.pb_oe;
  assign overflow_flag        = r_reg.ovf;
  assign compare_match_flag_a = flag_a;
  assign compare_match_flag_b = flag_b;

endmodule : tcwu_timer

// ### tcwu_timer_sva.sv
/*
 Port checker for tcwu_timer, attached by bind.
 Assumes one clock aclk and the synchronous active-low aresetn.
*/
module tcwu_timer_sva (
  input wire logic        aclk,
  input wire logic        aresetn,
  input wire logic        ovf_service_ack,
  input wire logic        cma_service_ack,
  input wire logic        s_axi_awvalid,
  input wire logic        s_axi_awready,
  input wire logic        s_axi_wvalid,
  input wire logic        s_axi_wready,
  input wire logic        s_axi_bvalid,
  input wire logic        s_axi_bready,
  input wire logic        s_axi_arvalid,
  input wire logic        s_axi_arready,
  input wire logic        s_axi_rvalid,
  input wire logic        s_axi_rready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic        pin_a_out,
  input wire logic        pin_a_oe,
  input wire logic        pin_b_out,
  input wire logic        pin_b_oe,
  input wire logic        overflow_flag,
  input wire logic        compare_match_flag_a
);
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);
  ////////////////////////////////////////////////////////////////
  sequence write_taken;
    s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
  endsequence
  sequence read_taken;
    s_axi_arvalid && s_axi_arready;
  endsequence
  chk_pin_a_quiet: assert property (!pin_a_oe |-> !pin_a_out)
    else $error("pin a level while undriven");
  chk_pin_b_quiet: assert property (!pin_b_oe |-> !pin_b_out)
    else $error("pin b level while undriven");
  // Direction only moves through a register write
  chk_oe_by_write: assert property ($changed(pin_a_oe) |-> $past(s_axi_wvalid, 2) || $past(s_axi_wvalid, 3))
    else $error("pin a enable moved without a write");
  chk_ovf_service: assert property (ovf_service_ack |=> !overflow_flag)
    else $error("overflow flag kept after service");
  chk_cma_service: assert property (cma_service_ack |=> !compare_match_flag_a)
    else $error("match flag a kept after service");
  chk_write_answer: assert property (write_taken |-> ##[1:3] s_axi_bvalid)
    else $error("write response late");
  chk_read_answer: assert property (read_taken |-> ##[1:3] s_axi_rvalid)
    else $error("read response late");
  chk_rvalid_hold: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
    else $error("read data dropped before ready");
  chk_bvalid_hold: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid)
    else $error("write response dropped before ready");
endmodule : tcwu_timer_sva

bind tcwu_timer tcwu_timer_sva u_tcwu_timer_sva (.aclk, .aresetn, .ovf_service_ack, .cma_service_ack,
  .s_axi_awvalid, .s_axi_awready, .s_axi_wvalid, .s_axi_wready, .s_axi_bvalid, .s_axi_bready,
  .s_axi_arvalid, .s_axi_arready, .s_axi_rvalid, .s_axi_rready, .s_axi_rdata, .pin_a_out,
  .pin_a_oe, .pin_b_out, .pin_b_oe, .overflow_flag, .compare_match_flag_a);

// ### tb_top.sv
/*
 Self-checking bench for tcwu_timer: AXI4-Lite register tasks, timer modes.
 Assumes the defines header and a timer tick held high once running.
*/
`include "tcwu_defines.svh"
module tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  typedef struct {logic rd; logic [1:0] rs; logic [31:0] d; logic [31:0] m;} tcwu_exp_t;
  logic aclk = 1'h0, aresetn = 1'h0, timer_tick_in = 1'h0, lv;
  logic ovf_service_ack = 1'h0, cma_service_ack = 1'h0, cmb_service_ack = 1'h0;
  logic s_axi_awvalid = 1'h0, s_axi_wvalid = 1'h0, s_axi_bready = 1'h0;
  logic s_axi_arvalid = 1'h0, s_axi_rready = 1'h0;
  logic [5:0] s_axi_awaddr = 6'h00, s_axi_araddr = 6'h00;
  logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata, cmp;
  logic [3:0] s_axi_wstrb = 4'hf;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  logic pin_a_out, pin_a_oe, pin_b_out, pin_b_oe;
  logic overflow_flag, compare_match_flag_a, compare_match_flag_b;
  logic [1:0] s_axi_bresp, s_axi_rresp;
  tcwu_exp_t expq[$], e;
  int n_mismatch = 0, compares = 0, hi, i;
  integer seed = 32'hd97d80f8;
  always #4 aclk = ~aclk;
  tcwu_timer u_tcwu_timer (.aclk, .aresetn, .timer_tick_in, .ovf_service_ack, .cma_service_ack,
    .cmb_service_ack, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb,
    .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr,
    .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready,
    .pin_a_out, .pin_a_oe, .pin_b_out, .pin_b_oe, .overflow_flag, .compare_match_flag_a,
    .compare_match_flag_b);
  ////////////////////////////////////////////////////////////////
  task automatic chk(string what, logic [31:0] ex, logic [31:0] got);
    compares++;
    if (got !== ex) begin
      n_mismatch++;
      $display("mismatch %s expected %h seen %h", what, ex, got);
    end
  endtask : chk
  task automatic wrap_up();
    $display("compares %0d n_mismatch %0d", compares, n_mismatch);
    if (n_mismatch == 0 && compares > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask : wrap_up
  // Answers come in order, so the oldest note pairs with each response
  always @(posedge aclk) begin
    if ((s_axi_bvalid && s_axi_bready) || (s_axi_rvalid && s_axi_rready)) begin
      e = expq.pop_front();
      chk("response", {30'h0, e.rs}, {30'h0, e.rd ? s_axi_rresp : s_axi_bresp});
      if (e.rd) chk("read data", e.d & e.m, s_axi_rdata & e.m);
    end
  end
  task automatic wr(logic [5:0] a, logic [31:0] d);
    int k = 0;
    @(posedge aclk);
    expq.push_back('{1'h0, 2'h0, 32'h0, 32'h0});
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'h1;
    s_axi_wvalid <= 1'h1;
    s_axi_bready <= 1'h1;
    do begin
      @(posedge aclk);
      if (s_axi_awready) s_axi_awvalid <= 1'h0;
      if (s_axi_wready) s_axi_wvalid <= 1'h0;
      k++;
    end while (!s_axi_bvalid && k < 60);
    s_axi_bready <= 1'h0;
    if (k == 60) chk("write answer in time", 32'h1, 32'h0);
    if (k == 60) wrap_up();
  endtask : wr
  task automatic rd(logic [5:0] a, logic [31:0] d, logic [31:0] m, logic [1:0] rs);
    int k = 0;
    @(posedge aclk);
    expq.push_back('{1'h1, rs, d, m});
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'h1;
    s_axi_rready <= 1'h1;
    do begin
      @(posedge aclk);
      if (s_axi_arready) s_axi_arvalid <= 1'h0;
      k++;
    end while (!s_axi_rvalid && k < 60);
    s_axi_rready <= 1'h0;
    if (k == 60) chk("read answer in time", 32'h1, 32'h0);
    if (k == 60) wrap_up();
  endtask : rd
  task automatic pins(logic eo, logic ev);
    repeat (4) @(posedge aclk);
    chk("pin a enable", {31'h0, eo}, {31'h0, pin_a_oe});
    chk("pin a level", {31'h0, ev}, {31'h0, pin_a_out});
  endtask : pins
  ////////////////////////////////////////////////////////////////
  initial begin
    repeat (2) @(posedge aclk);
    aresetn <= 1'h1;
    timer_tick_in <= 1'h1;
    rd(`TCWU_OFF_CTRL, 32'h0, 32'hffffffff, `TCWU_RESP_OKAY);
    rd(6'h20, 32'h0, 32'h0, `TCWU_RESP_SLVERR);
    wr(`TCWU_OFF_COUNT, 32'h5a);
    repeat (8) @(posedge aclk);
    rd(`TCWU_OFF_COUNT, 32'h5a, 32'hff, `TCWU_RESP_OKAY);
    wr(`TCWU_OFF_STROBE, 32'h5);
    wr(`TCWU_OFF_PORT, 32'h1);
    pins(1'h1, 1'h0);
    wr(`TCWU_OFF_CTRL, 32'h20);
    pins(1'h1, 1'h1);
    wr(`TCWU_OFF_STROBE, 32'h1);
    pins(1'h1, 1'h0);
    rd(`TCWU_OFF_FLAGS, 32'h0, 32'h2, `TCWU_RESP_OKAY);
    rd(`TCWU_OFF_COUNT, 32'h5a, 32'hff, `TCWU_RESP_OKAY);
    wr(`TCWU_OFF_PORT, 32'h0);
    pins(1'h0, 1'h0);
    $display("test preset and force done");
    wr(`TCWU_OFF_FLAGS, 32'h7);
    wr(`TCWU_OFF_COUNT, 32'hf0);
    wr(`TCWU_OFF_CTRL, 32'h100);
    for (i = 0; i < 60 && overflow_flag !== 1'h1; i++) @(posedge aclk);
    chk("overflow", 32'h1, {31'h0, overflow_flag});
    ovf_service_ack <= 1'h1;
    @(posedge aclk);
    ovf_service_ack <= 1'h0;
    repeat (2) @(posedge aclk);
    chk("overflow serviced", 32'h0, {31'h0, overflow_flag});
    $display("test normal done");
    wr(`TCWU_OFF_CMPA, 32'h0);
    wr(`TCWU_OFF_PORT, 32'h1);
    wr(`TCWU_OFF_CTRL, 32'h112);
    wr(`TCWU_OFF_COUNT, 32'h0);
    repeat (6) @(posedge aclk);
    for (i = 0; i < 4; i++) begin
      lv = pin_a_out;
      @(posedge aclk);
      chk("toggle", {31'h0, ~lv}, {31'h0, pin_a_out});
    end
    chk("match flag a", 32'h1, {31'h0, compare_match_flag_a});
    chk("match flag b", 32'h1, {31'h0, compare_match_flag_b});
    wr(`TCWU_OFF_CTRL, 32'h12);
    cma_service_ack <= 1'h1;
    cmb_service_ack <= 1'h1;
    @(posedge aclk);
    cma_service_ack <= 1'h0;
    cmb_service_ack <= 1'h0;
    repeat (2) @(posedge aclk);
    chk("match flag a serviced", 32'h0, {31'h0, compare_match_flag_a});
    chk("match flag b serviced", 32'h0, {31'h0, compare_match_flag_b});
    $display("test clear on match done");
    cmp = $random(seed);
    cmp = cmp & 32'h7f;
    for (i = 2; i < 4; i++) begin
      wr(`TCWU_OFF_CTRL, 32'h0);
      wr(`TCWU_OFF_FLAGS, 32'h7);
      wr(`TCWU_OFF_CMPA, cmp);
      wr(`TCWU_OFF_CTRL, 32'h103 | (i << 4));
      repeat (300) @(posedge aclk);
      hi = 0;
      repeat (256) begin
        @(posedge aclk);
        hi += pin_a_out;
      end
      chk("high cycles", i == 2 ? cmp + 32'h1 : 32'hff - cmp, hi);
      chk("overflow", 32'h1, {31'h0, overflow_flag});
    end
    $display("test fast pwm done");
    wrap_up();
  end
endmodule : tb_top
